// >>> fsc_counter.sv
`timescale 1ns/1ps
// Contract
// RL1 - the first stage is the least significant bit of the state number
// RL2 - every clock shifts one place and takes a feedback bit into stage one
// RL3 - basic mode toggles stage one while last stage is zero; all-ones persists
// RL4 - escape feedback gives zero in all-ones and one in all-zeros
// RL5 - alternative escape: all-ones detector clears the whole register
// RL6 - modulo-10 mode jumps from 1000 straight to 1100
// RL7 - up/down shifts either way; left input is zero when stages one and two differ
// RL8 - seven-bit up/down counter steps through a reversible loop of 127 states
// RL9 - divide mode uses basic feedback and loads when first three stages are one
// RL10 - system holds the divide preset on static switch inputs
// RL11 - seven-bit divide loads a per-divisor preset; 128 all ones, 127 stage one zero; here an all-ones preset reloads every cycle (divide by 1)
// RL12 - all updates on the rising edge; master reset clears to zeros
module fsc_counter #(
  parameter int WIDTH = fsc_pkg::FSC_DEF_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // static configuration pins
  input wire fsc_pkg::fsc_mode_e mode,
  input wire logic down,
  input wire logic [WIDTH-1:0] preset,
  // synchronous master clear pin
  input wire logic clr,
  // count and divided output
  output logic [WIDTH-1:0] count_q,
  output logic div_q
);

  typedef struct packed {
    fsc_pkg::fsc_mode_e mode;
    logic down;
    logic clr;
    logic [WIDTH-1:0] preset;
  } fsc_pins_s;

  typedef struct packed {
    fsc_pins_s s1;
    fsc_pins_s s2;
    fsc_pins_s s3;
    fsc_pins_s acc;
    logic [WIDTH-1:0] cnt;
    logic div;
  } fsc_state_s;

  // refuse lengths the jump and load detectors cannot address
  if (WIDTH < fsc_pkg::FSC_MIN_W || WIDTH > fsc_pkg::FSC_MAX_W) begin : g_width_check
    $error("fsc_counter: WIDTH out of range");
  end

  fsc_state_s st_q;
  fsc_state_s st_d;
  fsc_pins_s pins;
  logic all_ones;
  logic all_zero;
  logic basic_fb;
  logic load_hit;

  assign pins.mode = mode;
  assign pins.down = down;
  assign pins.clr = clr;
  assign pins.preset = preset;

  // decodes on the accepted state; stage one is the lsb of the number
  assign all_ones = &st_q.cnt; // see RL1
  assign all_zero = ~|st_q.cnt;
  assign basic_fb = st_q.cnt[0] ^ ~st_q.cnt[WIDTH-1]; // see RL3
  assign load_hit = &st_q.cnt[fsc_pkg::FSC_LOAD_DET_W-1:0]; // see RL9

  // next state: synchroniser chain, then one counter step
  always_comb begin
    st_d = st_q;
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // a pin change counts only once stages two and three agree
    if (st_q.s2 == st_q.s3) begin
      st_d.acc = st_q.s3;
    end
    // the divide pulse lasts one cycle unless the next reload follows at once
    st_d.div = 1'b0;
    // default step is a right shift with basic feedback into stage one
    st_d.cnt = {st_q.cnt[WIDTH-2:0], basic_fb}; // see RL2
    if (st_q.acc.clr) begin
      st_d.cnt = '0; // see RL12
    end else begin
      unique case (st_q.acc.mode)
        fsc_pkg::FSC_BASIC: begin
          st_d.cnt = {st_q.cnt[WIDTH-2:0], basic_fb}; // see RL3
        end
        fsc_pkg::FSC_ONESC: begin
          // forcing the feedback removes the all-ones one-state loop; all-zeros leaves under basic feedback too
          if (all_ones) begin
            st_d.cnt = {st_q.cnt[WIDTH-2:0], 1'b0}; // see RL4
          end else if (all_zero) begin
            st_d.cnt = {st_q.cnt[WIDTH-2:0], 1'b1}; // see RL4
          end
        end
        fsc_pkg::FSC_MRESC: begin
          // clear costs a full cycle but needs only a wide and-gate
          if (all_ones) begin
            st_d.cnt = '0; // see RL5
          end
        end
        fsc_pkg::FSC_MOD10: begin
          // hold stage one set in the jump state; skips five loop states
          if (st_q.cnt[3:0] == fsc_pkg::FSC_JUMP_FROM) begin
            st_d.cnt = {st_q.cnt[WIDTH-2:0], 1'b1}; // see RL6
          end
        end
        fsc_pkg::FSC_UPDN: begin
          // down is the exact inverse of the basic up step
          if (st_q.acc.down) begin
            st_d.cnt = {~(st_q.cnt[0] ^ st_q.cnt[1]), st_q.cnt[WIDTH-1:1]}; // see RL7, see RL8
          end
        end
        fsc_pkg::FSC_DIVN: begin
          // preset decides the divisor; the switches must stay static
          if (load_hit) begin
            st_d.cnt = st_q.acc.preset; // see RL9, see RL10, see RL11
            st_d.div = 1'b1;
          end
        end
        default: begin
          st_d.cnt = {st_q.cnt[WIDTH-2:0], basic_fb};
        end
      endcase
    end
  end

  // single state register, everything on the rising edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0; // see RL12
    end else begin
      st_q <= st_d;
    end
  end

  // both outputs are plain taps of the state register, no gating after the flops
  assign count_q = st_q.cnt;
  assign div_q = st_q.div;

  // ---- checks ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  logic shifting_right;
  assign shifting_right = !st_q.acc.clr
    && !(st_q.acc.mode == fsc_pkg::FSC_UPDN && st_q.acc.down)
    && !(st_q.acc.mode == fsc_pkg::FSC_MRESC && all_ones)
    && !(st_q.acc.mode == fsc_pkg::FSC_DIVN && load_hit);

  a_shift_one_place: assert property ( // see RL2
    shifting_right |=> count_q[WIDTH-1:1] == $past(count_q[WIDTH-2:0]))
    else $error("register did not shift by one place");

  a_basic_toggle: assert property ( // see RL3
    (st_q.acc.mode == fsc_pkg::FSC_BASIC && !st_q.acc.clr)
      |=> count_q[0] == ($past(count_q[0]) ^ ~$past(count_q[WIDTH-1])))
    else $error("basic feedback bit wrong");

  a_ones_persist: assert property ( // see RL3
    (st_q.acc.mode == fsc_pkg::FSC_BASIC && !st_q.acc.clr && all_ones)
      ##1 (st_q.acc.mode == fsc_pkg::FSC_BASIC && !st_q.acc.clr) |=> &count_q)
    else $error("all-ones state did not persist");

  a_escape_ones: assert property ( // see RL4
    (st_q.acc.mode == fsc_pkg::FSC_ONESC && !st_q.acc.clr && all_ones) |=> count_q[0] == 1'b0)
    else $error("escape did not feed zero in all-ones");

  a_escape_zeros: assert property ( // see RL4
    (st_q.acc.mode == fsc_pkg::FSC_ONESC && !st_q.acc.clr && all_zero) |=> count_q[0] == 1'b1)
    else $error("escape did not feed one in all-zeros");

  a_detect_clear: assert property ( // see RL5
    (st_q.acc.mode == fsc_pkg::FSC_MRESC && !st_q.acc.clr && all_ones) |=> count_q == '0)
    else $error("all-ones detector did not clear");

  a_mod10_jump: assert property ( // see RL6
    (st_q.acc.mode == fsc_pkg::FSC_MOD10 && !st_q.acc.clr
      && count_q[3:0] == fsc_pkg::FSC_JUMP_FROM) |=> count_q[3:0] == fsc_pkg::FSC_JUMP_TO)
    else $error("modulo-10 jump missed");

  a_down_reverses: assert property ( // see RL7
    (st_q.acc.mode == fsc_pkg::FSC_UPDN && !st_q.acc.clr && !st_q.acc.down)
      ##1 (st_q.acc.mode == fsc_pkg::FSC_UPDN && !st_q.acc.clr && st_q.acc.down)
      |=> count_q == $past(count_q, 2))
    else $error("down step did not undo up step");

  a_load_preset: assert property ( // see RL9
    (st_q.acc.mode == fsc_pkg::FSC_DIVN && !st_q.acc.clr && load_hit)
      |=> (count_q == $past(st_q.acc.preset)) && div_q)
    else $error("divide reload missed");

  a_clear_zero: assert property ( // see RL12
    st_q.acc.clr |=> count_q == '0 && !div_q)
    else $error("master clear did not zero the register");

  // a pulse with no reload behind it would double-count at the consumer
  a_div_single: assert property ( // see RL9
    div_q |-> $past(st_q.acc.mode == fsc_pkg::FSC_DIVN && !st_q.acc.clr && load_hit))
    else $error("divide pulse without a reload");

  // plain toggle feedback must leave the all-zero state on its own
  a_zero_leaves: assert property ( // see RL3
    (st_q.acc.mode == fsc_pkg::FSC_BASIC && !st_q.acc.clr && all_zero)
      |=> count_q == WIDTH'(1))
    else $error("basic loop stuck in all-zero state");

  // main scenarios the bench should reach

  c_mod10_jump: cover property (
    st_q.acc.mode == fsc_pkg::FSC_MOD10 && count_q[3:0] == fsc_pkg::FSC_JUMP_FROM);
  c_div_reload: cover property (div_q ##[1:40] div_q);
  c_detect_clear: cover property (st_q.acc.mode == fsc_pkg::FSC_MRESC && all_ones);
  c_down_step: cover property (st_q.acc.mode == fsc_pkg::FSC_UPDN && st_q.acc.down ##1 st_q.acc.down);
  c_ones_escape: cover property (st_q.acc.mode == fsc_pkg::FSC_ONESC && all_ones);

endmodule

// >>> fsc_pkg.sv
package fsc_pkg;

  // arrangement of the feedback around the shift register
  typedef enum logic [2:0] {
    FSC_BASIC = 3'h0, // toggle first stage while last stage is zero
    FSC_ONESC = 3'h1, // feedback forced out of all-ones and all-zeros
    FSC_MRESC = 3'h3, // all-ones detector clears the register
    FSC_MOD10 = 3'h2, // basic loop with the one jump
    FSC_UPDN  = 3'h6, // reversible right/left counter
    FSC_DIVN  = 3'h7  // basic loop with preset reload
  } fsc_mode_e;

  // register length limits the logic can serve
  localparam int FSC_MIN_W = 4;
  localparam int FSC_MAX_W = 22;
  localparam int FSC_DEF_W = 4;

  // modulo-10 jump: state 1000 (first stage set) goes straight to 1100
  localparam logic [3:0] FSC_JUMP_FROM = 4'h1;
  localparam logic [3:0] FSC_JUMP_TO = 4'h3;

  // reload fires when this many leading stages are all one
  localparam int FSC_LOAD_DET_W = 3;

  // synchroniser depth for pin inputs
  localparam int FSC_SYNC_DEPTH = 3;

  // reset value of the div output
  localparam logic FSC_DIV_RST = 1'b0;

endpackage

// >>> fsc_sink.sv
`timescale 1ns/1ps
module fsc_sink (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // divided pulse and tally
  input wire logic div,
  output logic [15:0] pulses_q
);
  // div is high for one cycle per reload, so counting high cycles counts reloads
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulses_q <= 16'h0000;
    end else begin
      pulses_q <= pulses_q + 16'(div);
    end
  end
endmodule

// >>> fsc_counter_tb.sv
`timescale 1ns/1ps
module fsc_counter_tb;
  logic ref_clk = 1'b0, rst_b = 1'b0, down = 1'b0, clr = 1'b0, div_q;
  logic [3:0] preset = 4'h0, count_q;
  logic [15:0] pulses_q;
  fsc_pkg::fsc_mode_e mode = fsc_pkg::FSC_BASIC;
  int err_count = 0, n_compared = 0;
  fsc_counter #(.WIDTH(4)) u_fsc_counter (.ref_clk(ref_clk), .rst_b(rst_b), .mode(mode), .down(down),
    .preset(preset), .clr(clr), .count_q(count_q), .div_q(div_q));
  fsc_sink u_fsc_sink (.ref_clk(ref_clk), .rst_b(rst_b), .div(div_q), .pulses_q(pulses_q));
  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // hang guard, far above the run length
  initial begin
    for (int i = 0; i < 8000; i++) @(posedge ref_clk);
    err_count++;
    tally_and_finish();
  end
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // expected next state; stage one is bit 0
  function automatic logic [3:0] nxt(logic [3:0] c);
    logic [3:0] b;
    b = {c[2:0], c[0] ^ ~c[3]};
    if (clr) return 4'h0;
    case (mode)
      fsc_pkg::FSC_ONESC: return (c == 4'hF) ? 4'hE : b;
      fsc_pkg::FSC_MRESC: return (c == 4'hF) ? 4'h0 : b;
      fsc_pkg::FSC_MOD10: return (c == 4'h1) ? 4'h3 : b;
      fsc_pkg::FSC_UPDN: return down ? {~(c[0] ^ c[1]), c[3:1]} : b;
      fsc_pkg::FSC_DIVN: return (c[2:0] == 3'h7) ? preset : b;
      default: return b;
    endcase
  endfunction
  // set pins, wait out the synchroniser, then follow n steps
  task automatic run(fsc_pkg::fsc_mode_e m, logic dn, logic [3:0] p, logic cl, int n);
    logic [3:0] c;
    mode = m;
    {down, preset, clr} = {dn, p, cl};
    // s1, s2, s3, then the accept stage: the fifth edge is the first step on the new pins
    repeat (4) @(negedge ref_clk);
    for (int i = 0; i < n; i++) begin
      c = count_q;
      @(negedge ref_clk);
      chk(16'(count_q), 16'(nxt(c)));
      chk(16'(div_q), 16'(mode == fsc_pkg::FSC_DIVN && !clr && c[2:0] == 3'h7));
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic t_modes();
    run(fsc_pkg::FSC_BASIC, 1'b0, 4'h0, 1'b0, 20);
    run(fsc_pkg::FSC_MOD10, 1'b0, 4'h0, 1'b0, 25);
    run(fsc_pkg::FSC_UPDN, 1'b1, 4'h0, 1'b0, 20);
    for (int p = 0; p < 15; p++) run(fsc_pkg::FSC_DIVN, 1'b0, 4'(p), 1'b0, 20);
  endtask
  // park at all ones by reloading, then see if m frees it
  task automatic t_lock(fsc_pkg::fsc_mode_e m);
    logic [15:0] b;
    run(fsc_pkg::FSC_DIVN, 1'b0, 4'hF, 1'b0, 16);
    b = pulses_q;
    repeat (8) @(negedge ref_clk);
    chk(pulses_q - b, 16'h0008);
    chk(16'(count_q), 16'h000F);
    run(fsc_pkg::FSC_BASIC, 1'b0, 4'hF, 1'b0, 4);
    run(m, 1'b0, 4'hF, 1'b0, 20);
  endtask
  // reset in mid-run, then clear while counting down
  task automatic t_reset();
    rst_b = 1'b0;
    #1;
    chk({11'h000, count_q, div_q}, 16'h0000);
    @(negedge ref_clk);
    rst_b = 1'b1;
    @(negedge ref_clk);
    chk(16'(count_q), 16'h0001);
    run(fsc_pkg::FSC_UPDN, 1'b1, 4'h0, 1'b1, 5);
  endtask
  // reset for 12 cycles, then the scenarios
  initial begin
    repeat (12) @(negedge ref_clk);
    rst_b = 1'b1;
    t_modes();
    t_lock(fsc_pkg::FSC_ONESC);
    t_lock(fsc_pkg::FSC_MRESC);
    t_reset();
    tally_and_finish();
  end
endmodule
